// ---- shared/afis_pkg.sv ----
// constants and carrier types for the optical front end interrupt status block
// assumes a register port already decoded from the serial interface
`default_nettype none
package afis_pkg;
  localparam logic [7:0] ADDR_FLAGS_PRI = 8'h00;
  localparam logic [7:0] ADDR_FLAGS_SEC = 8'h01;
  localparam logic [7:0] ADDR_ENABLE_PRI = 8'h02;
  localparam logic [7:0] ADDR_ENABLE_SEC = 8'h03;
  localparam logic [7:0] ADDR_FIFO_DATA = 8'h07;
  localparam logic [7:0] ADDR_FIFO_CFG = 8'h08;
  localparam int BIT_AFULL = 7;
  localparam int BIT_SAMPLE_READY = 6;
  localparam int BIT_AMBIENT_OVF = 5;
  localparam int BIT_PROX = 4;
  localparam int BIT_HEADROOM = 3;
  localparam int BIT_POWER_UP = 0;
  localparam int BIT_ANALOG_RANGE = 7;
  localparam int BIT_CLEAR_OPTION = 6;
  localparam int BIT_AFULL_ONESHOT = 5;
  localparam logic [7:0] MASK_FLAGS_PRI = 8'hF9;
  localparam logic [7:0] MASK_FLAGS_SEC = 8'h80;
  localparam logic [7:0] MASK_ENABLE_PRI = 8'hF8;
  localparam logic [7:0] MASK_ENABLE_SEC = 8'h80;
  localparam logic [7:0] MASK_FIFO_CFG = 8'h7F;
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_FIFO_CFG = 8'h0F;
  localparam logic [5:0] FIFO_DEPTH = 6'h20;
  localparam int CLK_HZ = 100_000_000;
  localparam int ANALOG_DELAY_MS = 10;
  localparam int ANALOG_DELAY_CYCLES = CLK_HZ / 1000 * ANALOG_DELAY_MS;

  typedef enum logic [1:0] {ACQ_IDLE, ACQ_LED1, ACQ_LED2, ACQ_DUAL} afis_acq_t;

  typedef struct packed {
    logic samplePush;
    logic [5:0] fifoLevel;
    afis_acq_t acqMode;
    logic ambientOverflow;
    logic proxBelowThreshold;
    logic sampleEnd;
    logic led1LowHeadroom;
    logic digitalSupplyLockout;
    logic softReset;
    logic analogSupplyOutOfRange;
  } afis_events_t;

  typedef struct packed {
    logic [7:0] addr;
    logic read;
    logic write;
    logic [7:0] wdata;
  } afis_req_t;
endpackage
`default_nettype wire

// ---- tb/afis_host.sv ----
// host model issuing register strobes
// assumes calls from the bench; drives at falling edges only
`default_nettype none
module afis_host (
  input wire logic core_clk,
  input wire logic [7:0] rdData,
  output var afis_pkg::afis_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req <= '{addr: a, read: 1'b0, write: 1'b1, wdata: d};
    @(negedge core_clk);
    req.write <= 1'b0;
  endtask
  // read data is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    req.addr <= a;
    req.read <= 1'b1;
    @(negedge core_clk);
    req.read <= 1'b0;
    d = rdData;
  endtask
endmodule
`default_nettype wire

// ---- tb/afis_status_checker.sv ----
// port checker of the interrupt status block
// assumes binding onto afis_status
`default_nettype none
module afis_status_checker #(parameter int ANALOG_DELAY = 20) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire afis_pkg::afis_req_t req,
  input wire afis_pkg::afis_events_t ev,
  input wire logic [7:0] rdData,
  input wire logic intN,
  input wire logic proxMode
);
  timeunit 1ns;
  timeprecision 1ps;
  import afis_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [31:0] oorCnt;
  logic rdPri, rdSec, quiet;
  assign rdPri = req.read && req.addr == ADDR_FLAGS_PRI;
  assign rdSec = req.read && req.addr == ADDR_FLAGS_SEC;
  assign quiet = !(ev.samplePush || ev.ambientOverflow || ev.sampleEnd || ev.softReset
    || ev.digitalSupplyLockout);
  // run length of the out-of-range level, since $past cannot reach that far
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      oorCnt <= '0;
    else
      oorCnt <= ev.analogSupplyOutOfRange ? oorCnt + 1 : '0;
  sec_reserved_a: assert property (rdSec |=> rdData[6:0] == 7'h00) else $error("sec");
  pri_reserved_a: assert property (rdPri |=> rdData[2:1] == 2'h0) else $error("pri");
  ambient_set_a: assert property (ev.ambientOverflow ##1 !rdPri ##1 !rdPri ##1 rdPri
    |=> rdData[5]) else $error("ovf");
  power_up_a: assert property ((ev.softReset || ev.digitalSupplyLockout) ##1 !rdPri
    ##1 rdPri |=> rdData[0]) else $error("pwr");
  read_clear_a: assert property (rdPri && quiet ##1 quiet ##1 rdPri
    |=> (rdData & MASK_FLAGS_PRI) == 8'h00) else $error("clr");
  data_read_zero_a: assert property (req.read && req.addr == ADDR_FIFO_DATA
    |=> rdData == 8'h00) else $error("fifo");
  read_hold_a: assert property (!req.read |=> $stable(rdData)) else $error("hold");
  analog_keep_a: assert property (rdSec && oorCnt > ANALOG_DELAY + 2 |=> rdData[7])
    else $error("oor");
  analog_delay_a: assert property (rdSec && $past(rdSec, 2) && oorCnt < ANALOG_DELAY
    |=> !rdData[7]) else $error("dly");
  int_idle_a: assert property ($rose(arst_n) |-> intN) else $error("int");
  cover property (!intN);
  cover property (proxMode);
  cover property (rdSec && oorCnt > ANALOG_DELAY + 2);
endmodule
bind afis_status afis_status_checker #(.ANALOG_DELAY(ANALOG_DELAY)) chk (.core_clk(core_clk),
  .arst_n(arst_n), .req(req), .ev(ev), .rdData(rdData), .intN(intN), .proxMode(proxMode));
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench of the interrupt status block
// assumes afis_host drives the register port; events driven here
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import afis_pkg::*;
  logic core_clk, arst_n, intN, proxMode;
  logic [7:0] rdData;
  afis_req_t req;
  afis_events_t ev, e;
  int mismatches, n_tests;
  afis_status #(.ANALOG_DELAY(20)) uut (.core_clk(core_clk), .arst_n(arst_n), .req(req),
    .ev(ev), .rdData(rdData), .intN(intN), .proxMode(proxMode));
  afis_host host (.core_clk(core_clk), .rdData(rdData), .req(req));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    chk(v, exp);
  endtask
  task automatic pulse();
    @(negedge core_clk);
    ev <= e;
    @(negedge core_clk);
    ev <= '0;
    e = '0;
  endtask
  task automatic close_out();
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20us;
    mismatches++;
    close_out();
  end
  initial begin
    {mismatches, n_tests, arst_n, ev, e} = '0;
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    rc(ADDR_FLAGS_SEC, 8'h00);
    rc(ADDR_ENABLE_PRI, 8'h00);
    rc(ADDR_FIFO_CFG, 8'h0F);
    host.wr(ADDR_FLAGS_PRI, 8'hFF);
    rc(ADDR_FLAGS_PRI, 8'h00);
    e.softReset = 1'b1;
    pulse();
    rc(ADDR_FLAGS_PRI, 8'h01);
    rc(ADDR_FLAGS_PRI, 8'h00);
    e.digitalSupplyLockout = 1'b1;
    pulse();
    rc(ADDR_FLAGS_PRI, 8'h01);
    host.wr(ADDR_ENABLE_PRI, 8'hFF);
    rc(ADDR_ENABLE_PRI, 8'hF8);
    e.ambientOverflow = 1'b1;
    pulse();
    @(negedge core_clk) chk({7'h00, intN}, 8'h00);
    rc(ADDR_FLAGS_PRI, 8'h20);
    @(negedge core_clk) chk({7'h00, intN}, 8'h01);
    e.samplePush = 1'b1;
    e.acqMode = ACQ_LED1;
    e.fifoLevel = 6'd16;
    pulse();
    rc(ADDR_FLAGS_PRI, 8'h40);
    {e.samplePush, e.fifoLevel} = {1'b1, 6'd17};
    pulse();
    rc(ADDR_FLAGS_PRI, 8'h80);
    {e.samplePush, e.fifoLevel} = {1'b1, 6'd17};
    pulse();
    rc(ADDR_FLAGS_PRI, 8'h80);
    host.wr(ADDR_FIFO_CFG, 8'h4F);
    e.samplePush = 1'b1;
    e.acqMode = ACQ_DUAL;
    e.fifoLevel = 6'd20;
    pulse();
    rc(ADDR_FIFO_DATA, 8'h00);
    rc(ADDR_FLAGS_PRI, 8'h00);
    host.wr(ADDR_FIFO_CFG, 8'h2F);
    e.samplePush = 1'b1;
    pulse();
    {e.samplePush, e.fifoLevel} = {1'b1, 6'd17};
    pulse();
    rc(ADDR_FLAGS_PRI, 8'h80);
    {e.samplePush, e.fifoLevel} = {1'b1, 6'd17};
    pulse();
    rc(ADDR_FLAGS_PRI, 8'h00);
    {e.sampleEnd, e.led1LowHeadroom, e.proxBelowThreshold} = 3'b111;
    pulse();
    chk({7'h00, proxMode}, 8'h01);
    rc(ADDR_FLAGS_PRI, 8'h08);
    e.sampleEnd = 1'b1;
    pulse();
    rc(ADDR_FLAGS_PRI, 8'h10);
    {e.sampleEnd, e.proxBelowThreshold} = 2'b11;
    pulse();
    host.wr(ADDR_ENABLE_PRI, 8'hE0);
    @(negedge core_clk) chk({7'h00, proxMode}, 8'h00);
    {e.sampleEnd, e.led1LowHeadroom} = 2'b11;
    pulse();
    rc(ADDR_FLAGS_PRI, 8'h00);
    host.wr(ADDR_ENABLE_SEC, 8'h80);
    @(negedge core_clk) ev.analogSupplyOutOfRange <= 1'b1;
    rc(ADDR_FLAGS_SEC, 8'h00);
    rc(ADDR_FLAGS_SEC, 8'h00);
    repeat (20) @(negedge core_clk);
    rc(ADDR_FLAGS_SEC, 8'h80);
    chk({7'h00, intN}, 8'h00);
    rc(ADDR_FLAGS_SEC, 8'h80);
    @(negedge core_clk) ev.analogSupplyOutOfRange <= 1'b0;
    rc(ADDR_FLAGS_SEC, 8'h80);
    rc(ADDR_FLAGS_SEC, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire

// ---- verilog/afis_status.sv ----
// interrupt status flags, enables and interrupt pin of the optical front end
// assumes register reads/writes arrive as one-cycle strobes synchronous to core_clk
`default_nettype none
module afis_status #(
  parameter int ANALOG_DELAY = afis_pkg::ANALOG_DELAY_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire afis_pkg::afis_req_t req,
  input wire afis_pkg::afis_events_t ev,
  output logic [7:0] rdData,
  output logic intN,
  output logic proxMode
);
  import afis_pkg::*;

  logic [7:0] flagsPri_reg, flagsPri_next;
  logic [7:0] flagsSec_reg, flagsSec_next;
  logic [7:0] enablePri_reg, enablePri_next;
  logic [7:0] enableSec_reg, enableSec_next;
  logic [7:0] fifoCfg_reg, fifoCfg_next;
  logic [7:0] rdData_reg, rdData_next;
  logic intN_reg, intN_next;
  logic proxMode_reg, proxMode_next;
  logic afullCond_reg, afullCond_next;
  logic [31:0] rangeCnt_reg, rangeCnt_next;

  function automatic logic hit(input afis_req_t r, input logic [7:0] a);
    hit = r.read && (r.addr == a);
  endfunction

  logic [6:0] levelAfter;
  logic afullNow;
  logic dataReadClear;
  logic priRead;
  logic setAfull;
  logic setReady;
  logic setProx;
  logic setHeadroom;
  logic setPower;
  logic rangeMet;
  logic [7:0] setPri;
  logic [7:0] clrPri;

  always_comb begin
    priRead = hit(req, ADDR_FLAGS_PRI);
    dataReadClear = hit(req, ADDR_FIFO_DATA) && fifoCfg_reg[BIT_CLEAR_OPTION];
    // free slots after this push below the programmed threshold
    levelAfter = {1'b0, ev.fifoLevel} + 7'h01;
    afullNow = levelAfter > ({1'b0, FIFO_DEPTH} - {3'h0, fifoCfg_reg[3:0]});
    afullCond_next = afullCond_reg;
    if (ev.samplePush) begin
      afullCond_next = afullNow;
    end
    // repeat type flags every push; one-shot only on entry
    setAfull = ev.samplePush && afullNow
      && (!fifoCfg_reg[BIT_AFULL_ONESHOT] || !afullCond_reg);
    setReady = ev.samplePush && (ev.acqMode != ACQ_IDLE)
      && enablePri_reg[BIT_SAMPLE_READY];
    setHeadroom = ev.sampleEnd && ev.led1LowHeadroom && enablePri_reg[BIT_HEADROOM];
    setPower = ev.digitalSupplyLockout || ev.softReset;
    setPri = 8'h00;
    setPri[BIT_AFULL] = setAfull;
    setPri[BIT_SAMPLE_READY] = setReady;
    setPri[BIT_AMBIENT_OVF] = ev.ambientOverflow;
    setPri[BIT_PROX] = setProx;
    setPri[BIT_HEADROOM] = setHeadroom;
    setPri[BIT_POWER_UP] = setPower;
    clrPri = priRead ? MASK_FLAGS_PRI : 8'h00;
    clrPri[BIT_AFULL] = priRead || dataReadClear;
    clrPri[BIT_SAMPLE_READY] = priRead || dataReadClear;
    // a set in the clearing cycle wins so no event is lost
    flagsPri_next = ((flagsPri_reg & ~clrPri) | setPri) & MASK_FLAGS_PRI;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flagsPri_reg <= RESET_FLAGS;
      afullCond_reg <= 1'b0;
    end else begin
      flagsPri_reg <= flagsPri_next;
      afullCond_reg <= afullCond_next;
    end
  end

  always_comb begin
    // without the enable the block never enters proximity mode
    proxMode_next = proxMode_reg;
    setProx = 1'b0;
    if (!enablePri_reg[BIT_PROX]) begin
      proxMode_next = 1'b0;
    end else if (ev.sampleEnd) begin
      if (!proxMode_reg && ev.proxBelowThreshold) begin
        proxMode_next = 1'b1;
      end else if (proxMode_reg && !ev.proxBelowThreshold) begin
        proxMode_next = 1'b0;
        setProx = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      proxMode_reg <= 1'b0;
    end else begin
      proxMode_reg <= proxMode_next;
    end
  end

  always_comb begin
    rangeCnt_next = 32'h0;
    rangeMet = 1'b0;
    // any return into range restarts the qualifying wait
    if (ev.analogSupplyOutOfRange) begin
      if (rangeCnt_reg >= 32'(ANALOG_DELAY)) begin
        rangeCnt_next = rangeCnt_reg;
        rangeMet = 1'b1;
      end else begin
        rangeCnt_next = rangeCnt_reg + 32'h1;
      end
    end
    flagsSec_next = flagsSec_reg;
    if (hit(req, ADDR_FLAGS_SEC)) begin
      flagsSec_next[BIT_ANALOG_RANGE] = 1'b0;
    end
    if (rangeMet) begin
      flagsSec_next[BIT_ANALOG_RANGE] = 1'b1;
    end
    flagsSec_next = flagsSec_next & MASK_FLAGS_SEC;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flagsSec_reg <= RESET_FLAGS;
      rangeCnt_reg <= 32'h0;
    end else begin
      flagsSec_reg <= flagsSec_next;
      rangeCnt_reg <= rangeCnt_next;
    end
  end

  always_comb begin
    enablePri_next = enablePri_reg;
    enableSec_next = enableSec_reg;
    fifoCfg_next = fifoCfg_reg;
    if (req.write) begin
      unique case (req.addr)
        ADDR_ENABLE_PRI: enablePri_next = req.wdata & MASK_ENABLE_PRI;
        ADDR_ENABLE_SEC: enableSec_next = req.wdata & MASK_ENABLE_SEC;
        ADDR_FIFO_CFG: fifoCfg_next = req.wdata & MASK_FIFO_CFG;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enablePri_reg <= RESET_ENABLE;
      enableSec_reg <= RESET_ENABLE;
      fifoCfg_reg <= RESET_FIFO_CFG;
    end else begin
      enablePri_reg <= enablePri_next;
      enableSec_reg <= enableSec_next;
      fifoCfg_reg <= fifoCfg_next;
    end
  end

  always_comb begin
    // read data shows the flags as they stood before the clearing read
    rdData_next = rdData_reg;
    if (req.read) begin
      unique case (req.addr)
        ADDR_FLAGS_PRI: rdData_next = flagsPri_reg;
        ADDR_FLAGS_SEC: rdData_next = flagsSec_reg;
        ADDR_ENABLE_PRI: rdData_next = enablePri_reg;
        ADDR_ENABLE_SEC: rdData_next = enableSec_reg;
        ADDR_FIFO_CFG: rdData_next = fifoCfg_reg;
        default: rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  always_comb begin
    // power-up flag has no enable bit and never drives the pin
    intN_next = !(|(flagsPri_next & enablePri_next)
      || |(flagsSec_next & enableSec_next));
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      intN_reg <= 1'b1;
    end else begin
      intN_reg <= intN_next;
    end
  end

  assign rdData = rdData_reg;
  assign intN = intN_reg;
  assign proxMode = proxMode_reg;
endmodule
`default_nettype wire
